// ### iep_defines.vh
// constants of the interrupt enable and priority register block
// Operation
// - bit 7 of core mask is global gate; 0 blocks every source.
// - core mask bits 6..0 mask spi, timer2, uart, timer1, ext1, timer0, ext0.
// - timer two mask gates one request from low or high overflow.
// - timer one/zero masks gate overflows; ext masks gate pin requests.
// - core mask at 0xa8, all pages, bit-addressable, all rw, reset zero.
// - core level bits 6..0 give low (0) or high (1) per source.
// - core level bit 7 unused, reads 1, writes ignored.
// - core level at 0xb8, bit-addressable, level bits reset to zero.
// - extended mask bit 7 gates timer three low or high overflow.
// - extended mask bit 6 unused, reads 0, writes ignored.
// - extended mask bit 5 gates comparator rising or falling flag.
// - extended bit 4 gates counter array; bit 0 gates smbus.
// - extended bit 3 gates conversion done request.
// - extended bit 2 gates window compare request.
// - extended bit 1 gates real time clock alarm request.
// - extended mask at 0xe6, all pages, resets to all zeros.
// - pending requests sampled and priority decoded every clock.
// - hold new request while equal or higher handler runs.
`ifndef IEP_DEFINES_VH
`define IEP_DEFINES_VH
`define IEP_ADDR_CORE_MASK  8'ha8
`define IEP_ADDR_CORE_LEVEL 8'hb8
`define IEP_ADDR_EXT_MASK   8'he6
`define IEP_RST_CORE_MASK   8'h00
`define IEP_RST_CORE_LEVEL  7'h00
`define IEP_RST_EXT_MASK    8'h00
`define IEP_GLOBAL_BIT      7
`define IEP_LEVEL_RD_ONE    1'b1
`define IEP_EXT_UNUSED_BIT  6
`define IEP_NO_SOURCE       5'h1f
`endif

// ### iep_pick.v
// fixed-order picker: lowest set request index at one level
`timescale 1ns/10ps
module iep_pick #(
    parameter N  = 15,
    parameter IW = 5
) (
    input  wire [N-1:0]  req_in,
    output reg           any_out,
    output reg  [IW-1:0] idx_out
);
    integer i;
    // scan downward so the lowest index wins the tie
    always @* begin
        any_out = 1'b0;
        idx_out = {IW{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req_in[i]) begin
                any_out = 1'b1;
                idx_out = i[IW-1:0];
            end
        end
    end
endmodule // iep_pick

// ### iep_regs.v
// interrupt enable and priority registers with request decoder
`timescale 1ns/10ps
`include "iep_defines.vh"
module iep_regs #(
    parameter NSRC = 15
) (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    // avalon-mm slave
    input  wire [7:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output wire        avs_waitrequest_out,
    output reg  [31:0] avs_readdata_out,
    output reg  [1:0]  avs_response_out,
    // pending flags from peripherals
    input  wire        ext_pin_zero_in,
    input  wire        timer_zero_overflow_in,
    input  wire        ext_pin_one_in,
    input  wire        timer_one_overflow_in,
    input  wire        uart_flag_in,
    input  wire        timer_two_low_overflow_in,
    input  wire        timer_two_high_overflow_in,
    input  wire        serial_periph_flag_in,
    input  wire        smbus_flag_in,
    input  wire        rtc_alarm_flag_in,
    input  wire        window_compare_flag_in,
    input  wire        conversion_done_flag_in,
    input  wire        counter_array_flag_in,
    input  wire        comparator_rising_flag_in,
    input  wire        comparator_falling_flag_in,
    input  wire        timer_three_low_overflow_in,
    input  wire        timer_three_high_overflow_in,
    // extended priority bits held elsewhere, one per source 7..14
    input  wire [7:0]  ext_level_in,
    // cpu sequencer handshake
    input  wire        irq_ack_in,
    input  wire        isr_return_in,
    input  wire        next_instr_done_in,
    // gated requests and decode result
    output reg  [14:0] gated_req_out,
    output reg  [14:0] req_level_out,
    output reg         irq_req_out,
    output reg  [4:0]  irq_source_out,
    output reg         irq_high_out,
    output wire [7:0]  core_source_mask_out,
    output wire [7:0]  core_source_level_out,
    output wire [7:0]  extended_source_mask_one_out
);
    reg  [7:0]  core_source_mask_q;
    reg  [6:0]  core_level_q;
    reg  [7:0]  ext_mask_q;
    // handler nesting: bit 0 low running, bit 1 high running
    reg  [1:0]  active_q;
    reg         wait_instr_q;
    reg  [14:0] raw_req;
    reg  [14:0] en_mask;
    wire [14:0] enabled;
    wire [14:0] lvl_all;
    wire [14:0] hi_req;
    wire [14:0] lo_req;
    wire        hi_any;
    wire        lo_any;
    wire [4:0]  hi_idx;
    wire [4:0]  lo_idx;
    reg         take_hi;
    reg         take_lo;
    reg         rd_ack_q;
    wire        hit_core_mask;
    wire        hit_core_level;
    wire        hit_ext_mask;
    wire        wr_ok;

    // source order: 0 ext0, 1 t0, 2 ext1, 3 t1, 4 uart, 5 t2, 6 spi,
    // 7 smbus, 8 rtc, 9 window, 10 conv, 11 pca, 12 comp, 13 none, 14 t3
    always @* begin
        raw_req     = 15'h0000;
        raw_req[0]  = ext_pin_zero_in;
        raw_req[1]  = timer_zero_overflow_in;
        raw_req[2]  = ext_pin_one_in;
        raw_req[3]  = timer_one_overflow_in;
        raw_req[4]  = uart_flag_in;
        raw_req[5]  = timer_two_low_overflow_in
                    | timer_two_high_overflow_in;
        raw_req[6]  = serial_periph_flag_in;
        raw_req[7]  = smbus_flag_in;
        raw_req[8]  = rtc_alarm_flag_in;
        raw_req[9]  = window_compare_flag_in;
        raw_req[10] = conversion_done_flag_in;
        raw_req[11] = counter_array_flag_in;
        raw_req[12] = comparator_rising_flag_in
                    | comparator_falling_flag_in;
        raw_req[14] = timer_three_low_overflow_in
                    | timer_three_high_overflow_in;
    end

    // per-source mask lanes in source order
    always @* begin
        en_mask        = 15'h0000;
        en_mask[6:0]   = core_source_mask_q[6:0];
        en_mask[7]     = ext_mask_q[0];
        en_mask[8]     = ext_mask_q[1];
        en_mask[9]     = ext_mask_q[2];
        en_mask[10]    = ext_mask_q[3];
        en_mask[11]    = ext_mask_q[4];
        en_mask[12]    = ext_mask_q[5];
        en_mask[14]    = ext_mask_q[7];
    end

    // global gate overrides every individual mask
    assign enabled = raw_req & en_mask
                   & {15{core_source_mask_q[`IEP_GLOBAL_BIT]}};
    assign lvl_all = {ext_level_in, core_level_q};
    assign hi_req  = enabled & lvl_all;
    assign lo_req  = enabled & ~lvl_all;

    iep_pick #(.N(15), .IW(5)) u_pick_hi (
        .req_in  (hi_req),
        .any_out (hi_any),
        .idx_out (hi_idx)
    );
    iep_pick #(.N(15), .IW(5)) u_pick_lo (
        .req_in  (lo_req),
        .any_out (lo_any),
        .idx_out (lo_idx)
    );

    // a request may preempt only a strictly lower running level
    always @* begin
        take_hi = hi_any & ~active_q[1] & ~wait_instr_q;
        take_lo = lo_any & (active_q == 2'b00) & ~wait_instr_q;
    end

    // sample and decode every clock
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gated_req_out  <= 15'h0000;
            req_level_out  <= 15'h0000;
            irq_req_out    <= 1'b0;
            irq_source_out <= `IEP_NO_SOURCE;
            irq_high_out   <= 1'b0;
        end else begin
            gated_req_out  <= enabled;
            req_level_out  <= lvl_all & enabled;
            irq_req_out    <= take_hi | take_lo;
            irq_high_out   <= take_hi;
            if (take_hi) begin
                irq_source_out <= hi_idx;
            end else if (take_lo) begin
                irq_source_out <= lo_idx;
            end else begin
                irq_source_out <= `IEP_NO_SOURCE;
            end
        end
    end

    // running handler tracking; after return one instruction must finish
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            active_q     <= 2'b00;
            wait_instr_q <= 1'b0;
        end else begin
            if (irq_ack_in && irq_req_out) begin
                if (irq_high_out) begin
                    active_q[1] <= 1'b1;
                end else begin
                    active_q[0] <= 1'b1;
                end
            end else if (isr_return_in) begin
                if (active_q[1]) begin
                    active_q[1] <= 1'b0;
                end else begin
                    active_q[0] <= 1'b0;
                end
                wait_instr_q <= 1'b1;
            end else if (wait_instr_q && next_instr_done_in) begin
                wait_instr_q <= 1'b0;
            end
        end
    end

    // avalon slave: zero wait state writes, one wait state reads
    assign hit_core_mask  = (avs_address_in == `IEP_ADDR_CORE_MASK);
    assign hit_core_level = (avs_address_in == `IEP_ADDR_CORE_LEVEL);
    assign hit_ext_mask   = (avs_address_in == `IEP_ADDR_EXT_MASK);
    assign wr_ok          = avs_write_in & avs_byteenable_in[0];
    assign avs_waitrequest_out = avs_read_in & ~rd_ack_q;

    // register writes; only byte lane 0 carries data
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            core_source_mask_q <= `IEP_RST_CORE_MASK;
            core_level_q       <= `IEP_RST_CORE_LEVEL;
            ext_mask_q         <= `IEP_RST_EXT_MASK;
        end else if (wr_ok) begin
            if (hit_core_mask) begin
                core_source_mask_q <= avs_writedata_in[7:0];
            end else if (hit_core_level) begin
                core_level_q <= avs_writedata_in[6:0];
            end else if (hit_ext_mask) begin
                ext_mask_q <= avs_writedata_in[7:0]
                            & 8'hbf;
            end
        end
    end

    // read data registered, one cycle after the request
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_ack_q         <= 1'b0;
            avs_readdata_out <= 32'h00000000;
            avs_response_out <= 2'b00;
        end else begin
            rd_ack_q <= avs_read_in & ~rd_ack_q;
            if (avs_read_in && !rd_ack_q) begin
                avs_response_out <= 2'b00;
                if (hit_core_mask) begin
                    avs_readdata_out <= {24'h000000, core_source_mask_q};
                end else if (hit_core_level) begin
                    avs_readdata_out <= {24'h000000, `IEP_LEVEL_RD_ONE,
                                         core_level_q};
                end else if (hit_ext_mask) begin
                    avs_readdata_out <= {24'h000000, ext_mask_q};
                end else begin
                    avs_readdata_out <= 32'h00000000;
                    avs_response_out <= 2'b10;
                end
            end
        end
    end

    assign core_source_mask_out         = core_source_mask_q;
    assign core_source_level_out        = {`IEP_LEVEL_RD_ONE, core_level_q};
    assign extended_source_mask_one_out = ext_mask_q;
endmodule // iep_regs

// ### iep_sva.sv
// port assertions for the interrupt enable and priority registers
`timescale 1ns/10ps
module iep_chk (
    input wire        clk_in,
    input wire        sys_rst_in,
    input wire [7:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0]  avs_byteenable_in,
    input wire        avs_waitrequest_out,
    input wire [31:0] avs_readdata_out,
    input wire [1:0]  avs_response_out,
    input wire [14:0] gated_req_out,
    input wire        irq_req_out,
    input wire [4:0]  irq_source_out,
    input wire [7:0]  core_source_mask_out,
    input wire [7:0]  core_source_level_out,
    input wire [7:0]  extended_source_mask_one_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // accepted strobes and address decode
    wire [7:0] wd     = avs_writedata_in[7:0];
    wire       wr_ok  = avs_write_in && avs_byteenable_in[0];
    wire       rd_ok  = avs_read_in && !avs_waitrequest_out;
    wire       mapped = avs_address_in == 8'ha8 ||
                        avs_address_in == 8'hb8 || avs_address_in == 8'he6;
    a_mask_write: assert property (
        wr_ok && avs_address_in == 8'ha8 |=>
        core_source_mask_out == $past(wd)) else $error("core mask write");
    a_level_write: assert property (
        wr_ok && avs_address_in == 8'hb8 |=>
        core_source_level_out == ($past(wd) | 8'h80))
        else $error("level write");
    a_ext_write: assert property (
        wr_ok && avs_address_in == 8'he6 |=>
        extended_source_mask_one_out == ($past(wd) & 8'hbf))
        else $error("extended mask write");
    a_level_top: assert property (core_source_level_out[7])
        else $error("level bit 7 not one");
    a_ext_six: assert property (!extended_source_mask_one_out[6])
        else $error("extended bit 6 not zero");
    a_gate_off: assert property (
        !core_source_mask_out[7] [*3] |-> gated_req_out == 15'h0000)
        else $error("request passed closed gate");
    a_rd_wait: assert property (
        $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("read wait state wrong");
    a_wr_nowait: assert property (
        avs_write_in |-> !avs_waitrequest_out) else $error("write stalled");
    a_unmapped_rd: assert property (
        rd_ok && !mapped |-> avs_response_out == 2'b10 &&
        avs_readdata_out == 32'h0) else $error("unmapped read answer");
    a_no_reserved: assert property (!gated_req_out[13])
        else $error("reserved source raised");
    a_idle_src: assert property (
        !irq_req_out |-> irq_source_out == 5'h1f) else $error("idle index");
endmodule // iep_chk
bind iep_regs iep_chk i_chk (.clk_in, .sys_rst_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_waitrequest_out, .avs_readdata_out, .avs_response_out,
    .gated_req_out, .irq_req_out, .irq_source_out, .core_source_mask_out,
    .core_source_level_out, .extended_source_mask_one_out);

// ### iep_cpu_model.sv
// cpu sequencer model: takes a request, runs a handler, returns
`timescale 1ns/10ps
module iep_cpu_model (
    input  wire clk_in,
    input  wire en_in,
    input  wire irq_req_in,
    output reg  ack_out = 1'b0,
    output reg  ret_out = 1'b0,
    output reg  done_out = 1'b0
);
    reg [4:0] cnt_q = 5'h00;
    // one ack, return after the handler, then one instruction done
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        ret_out <= cnt_q == 5'h03;
        done_out <= cnt_q == 5'h01;
        if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
        else if (en_in && irq_req_in && !ack_out) begin
            ack_out <= 1'b1;
            cnt_q <= 5'h14;
        end
    end
endmodule // iep_cpu_model

// ### testbench.sv
// self-checking bench for the interrupt enable and priority registers
`timescale 1ns/10ps
module testbench;
    reg         clk_in = 1'b0;
    reg         sys_rst_in = 1'b1;
    reg  [7:0]  avs_address_in = 8'h00;
    reg         avs_read_in = 1'b0;
    reg         avs_write_in = 1'b0;
    reg  [31:0] avs_writedata_in = 32'h0;
    reg  [3:0]  avs_byteenable_in = 4'h1;
    reg  [16:0] flg = 17'h0;
    reg  [7:0]  ext_level_in = 8'h00;
    reg         en = 1'b0;
    wire        avs_waitrequest_out, irq_ack_in, isr_return_in;
    wire        next_instr_done_in, irq_req_out, irq_high_out;
    wire [31:0] avs_readdata_out;
    wire [1:0]  avs_response_out;
    wire [14:0] gated_req_out, req_level_out;
    wire [4:0]  irq_source_out;
    wire [7:0]  core_source_mask_out, core_source_level_out;
    wire [7:0]  extended_source_mask_one_out;
    integer     failures = 0, checked = 0, n, k;
    always #2 clk_in = ~clk_in;
    iep_regs i_dut (.clk_in, .sys_rst_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_waitrequest_out, .avs_readdata_out, .avs_response_out,
        .ext_pin_zero_in(flg[0]), .timer_zero_overflow_in(flg[1]),
        .ext_pin_one_in(flg[2]), .timer_one_overflow_in(flg[3]),
        .uart_flag_in(flg[4]), .timer_two_low_overflow_in(flg[5]),
        .timer_two_high_overflow_in(flg[6]), .serial_periph_flag_in(flg[7]),
        .smbus_flag_in(flg[8]), .rtc_alarm_flag_in(flg[9]),
        .window_compare_flag_in(flg[10]), .conversion_done_flag_in(flg[11]),
        .counter_array_flag_in(flg[12]), .comparator_rising_flag_in(flg[13]),
        .comparator_falling_flag_in(flg[14]),
        .timer_three_low_overflow_in(flg[15]),
        .timer_three_high_overflow_in(flg[16]), .ext_level_in, .irq_ack_in,
        .isr_return_in, .next_instr_done_in, .gated_req_out, .req_level_out,
        .irq_req_out, .irq_source_out, .irq_high_out, .core_source_mask_out,
        .core_source_level_out, .extended_source_mask_one_out);
    iep_cpu_model i_cpu (.clk_in, .en_in(en), .irq_req_in(irq_req_out),
        .ack_out(irq_ack_in), .ret_out(isr_return_in),
        .done_out(next_instr_done_in));
    // source order number of each flag input
    function [4:0] src(input integer f);
        src = (f < 6) ? f : (f < 14) ? f - 1 : (f == 14) ? 12 : 14;
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task hang;
        failures = failures + 1;
        final_report;
    endtask
    task tick(input integer c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask
    // bus cycles: hold the request until waitrequest is sampled low
    task wait_ready;
        @(posedge clk_in);
        for (n = 0; avs_waitrequest_out !== 1'b0; n = n + 1) begin
            if (n == 50) hang;
            @(posedge clk_in);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= 1'b1;
        wait_ready;
        avs_write_in <= 1'b0;
    endtask
    task rdx(input [7:0] a, input [31:0] exp, input [1:0] r);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_read_in <= 1'b1;
        wait_ready;
        chk(avs_readdata_out, exp);
        chk(avs_response_out, r);
        avs_read_in <= 1'b0;
    endtask
    task t_regs;
        rdx(8'ha8, 32'h00, 2'b00);
        rdx(8'hb8, 32'h80, 2'b00);
        rdx(8'he6, 32'h00, 2'b00);
        rdx(8'h10, 32'h00, 2'b10);
        wr(8'hb8, 8'hff);
        rdx(8'hb8, 32'hff, 2'b00);
        wr(8'hb8, 8'h00);
        rdx(8'hb8, 32'h80, 2'b00);
        wr(8'he6, 8'hff);
        rdx(8'he6, 32'hbf, 2'b00);
        wr(8'ha8, 8'h5a);
        rdx(8'ha8, 32'h5a, 2'b00);
        avs_byteenable_in <= 4'h0;
        wr(8'ha8, 8'h00);
        avs_byteenable_in <= 4'h1;
        rdx(8'ha8, 32'h5a, 2'b00);
        $display("t_regs done");
    endtask
    task t_gate;
        @(posedge clk_in);
        flg <= 17'h1ffff;
        wr(8'ha8, 8'h7f);
        tick(4);
        chk(gated_req_out, 32'h0);
        for (k = 0; k < 17; k = k + 1) begin
            wr(8'ha8, 8'hff);
            wr(8'he6, 8'hff);
            flg <= 17'h1 << k;
            tick(4);
            chk(gated_req_out, 32'h1 << src(k));
            if (src(k) < 7) wr(8'ha8, 8'hff ^ (8'h1 << src(k)));
            else wr(8'he6, 8'hff ^ (8'h1 << (src(k) - 7)));
            tick(4);
            chk(gated_req_out, 32'h0);
        end
        $display("t_gate done");
    endtask
    task prio(input [7:0] lv, input [7:0] el, input [4:0] s, input h);
        wr(8'hb8, lv);
        ext_level_in <= el;
        tick(4);
        chk(irq_source_out, s);
        chk(irq_high_out, h);
        chk(req_level_out, {el[0], 2'h0, lv[4], 3'h0, lv[0]});
    endtask
    task t_prio;
        wr(8'ha8, 8'hff);
        wr(8'he6, 8'hff);
        flg <= 17'h00111;
        prio(8'h00, 8'h00, 5'h00, 1'b0);
        prio(8'h10, 8'h00, 5'h04, 1'b1);
        prio(8'h00, 8'h01, 5'h07, 1'b1);
        prio(8'h10, 8'h01, 5'h04, 1'b1);
        $display("t_prio done");
    endtask
    task t_hold;
        wr(8'hb8, 8'h00);
        ext_level_in <= 8'h00;
        flg <= 17'h1;
        en <= 1'b1;
        for (n = 0; irq_ack_in !== 1'b1; n = n + 1) begin
            if (n == 50) hang;
            @(posedge clk_in);
        end
        en <= 1'b0;
        flg <= 17'h2;
        tick(4);
        chk(irq_req_out, 1'b0);
        for (n = 0; irq_req_out !== 1'b1; n = n + 1) begin
            if (n == 60) hang;
            tick(1);
        end
        chk(irq_source_out, 5'h01);
        $display("t_hold done");
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_regs;
        t_gate;
        t_prio;
        t_hold;
        final_report;
    end
    initial begin
        #200000;
        hang;
    end
endmodule // testbench
